// ==== src/pic_pkg.sv ====
// Shared constants and the source-to-trap-number map of the interrupt controller.
package pic_pkg;
    localparam int N_SRC_MAX = 56;
    localparam int IDX_W     = 6;
    localparam int TRAP_W    = 7;
    localparam int VEC_W     = 9;
    localparam int LVL_W     = 4;
    localparam int GRP_W     = 2;
    localparam int CW_W      = 8;
    localparam int N_HWTRAP  = 4;
    localparam int GRP_LSB   = 0;
    localparam int LVL_LSB   = 2;
    localparam int EN_BIT    = 6;
    localparam int REQ_BIT   = 7;
    localparam logic [CW_W-1:0] CW_RST = 8'h00;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CW   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_TFR  = 12'h100;
    localparam logic [ADDR_W-1:0] ADDR_IST  = 12'h104;
    localparam logic [ADDR_W-1:0] ADDR_IMSK = 12'h108;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h10c;
    localparam int IST_TRAP = 0;
    localparam int IST_ACK  = 1;
    localparam int IST_W    = 2;
    localparam int IDX_CC_MID = 16;
    localparam int IDX_CC_HI  = 29;
    localparam int IDX_CT0    = 32;
    localparam int IDX_CT7    = 34;
    localparam int IDX_GPT    = 36;
    localparam int IDX_SER    = 44;
    localparam int IDX_XP     = 52;
    localparam logic [TRAP_W-1:0] TN_CC_LO  = 7'h10;
    localparam logic [TRAP_W-1:0] TN_CC_MID = 7'h30;
    localparam logic [TRAP_W-1:0] TN_CC_HI  = 7'h44;
    localparam logic [TRAP_W-1:0] TN_CT0    = 7'h20;
    localparam logic [TRAP_W-1:0] TN_CT7    = 7'h3d;
    localparam logic [TRAP_W-1:0] TN_GPT    = 7'h22;
    localparam logic [TRAP_W-1:0] TN_XP     = 7'h40;
    // Serial ports then the pulse width unit, lowest index first.
    localparam logic [8*TRAP_W-1:0] TN_SER =
        {7'h3f, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2b, 7'h47, 7'h2a};
    // Hardware traps, lowest priority first.
    localparam logic [N_HWTRAP*TRAP_W-1:0] TN_HW = {7'h02, 7'h04, 7'h06, 7'h0a};

    function automatic logic [TRAP_W-1:0] src_trap_num(input int idx);
        logic [TRAP_W-1:0] tn;
        tn = TN_XP + TRAP_W'(idx - IDX_XP);
        if (idx < IDX_CC_MID) begin
            tn = TN_CC_LO + TRAP_W'(idx);
        end else if (idx < IDX_CC_HI) begin
            tn = TN_CC_MID + TRAP_W'(idx - IDX_CC_MID);
        end else if (idx < IDX_CT0) begin
            tn = TN_CC_HI + TRAP_W'(idx - IDX_CC_HI);
        end else if (idx < IDX_CT7) begin
            tn = TN_CT0 + TRAP_W'(idx - IDX_CT0);
        end else if (idx < IDX_GPT) begin
            tn = TN_CT7 + TRAP_W'(idx - IDX_CT7);
        end else if (idx < IDX_SER) begin
            tn = TN_GPT + TRAP_W'(idx - IDX_GPT);
        end else if (idx < IDX_XP) begin
            tn = TN_SER[(idx - IDX_SER)*TRAP_W +: TRAP_W];
        end
        return tn;
    endfunction
endpackage

// ==== src/pic_arb_if.sv ====
// Interface between the register file and the request arbiter.
`timescale 1ns/1ps
interface pic_arb_if #(
    parameter int N = 56
);
    logic [pic_pkg::CW_W-1:0]  ctrl [N];
    logic                      win_valid;
    logic [pic_pkg::IDX_W-1:0] win_idx;
    logic [pic_pkg::LVL_W-1:0] win_lvl;
    modport arb (input ctrl, output win_valid, win_idx, win_lvl);
    modport top (output ctrl, input win_valid, win_idx, win_lvl);
endinterface

// ==== src/pic_arbiter.sv ====
// Registered priority arbiter over all enabled pending sources.
`timescale 1ns/1ps
module pic_arbiter #(
    parameter int N = 56
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Control words in, winner out.
    pic_arb_if.arb   ab
);
    localparam int KEY_W = pic_pkg::LVL_W + pic_pkg::GRP_W;

    logic                      any_nxt;
    logic [pic_pkg::IDX_W-1:0] idx_nxt;
    logic [KEY_W-1:0]          key_nxt;

    always_comb begin
        logic [KEY_W-1:0] key;
        key     = '0;
        any_nxt = 1'b0;
        idx_nxt = '0;
        key_nxt = '0;
        for (int i = 0; i < N; i++) begin
            key = ab.ctrl[i][pic_pkg::GRP_LSB +: KEY_W];
            if (ab.ctrl[i][pic_pkg::REQ_BIT] && ab.ctrl[i][pic_pkg::EN_BIT] &&
                (!any_nxt || key > key_nxt)) begin
                any_nxt = 1'b1;
                idx_nxt = pic_pkg::IDX_W'(i);
                key_nxt = key;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ab.win_valid <= 1'b0;
            ab.win_idx   <= '0;
            ab.win_lvl   <= '0;
        end else begin
            ab.win_valid <= any_nxt;
            ab.win_idx   <= idx_nxt;
            ab.win_lvl   <= key_nxt[pic_pkg::GRP_W +: pic_pkg::LVL_W];
        end
    end

    a_winner_enabled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ab.win_valid |-> $past(ab.ctrl[idx_nxt][pic_pkg::REQ_BIT] && ab.ctrl[idx_nxt][pic_pkg::EN_BIT]) &&
        ab.win_lvl == $past(ab.ctrl[idx_nxt][pic_pkg::LVL_LSB +: pic_pkg::LVL_W]))
        else $error("Arbiter winner without an enabled request.");
endmodule

// ==== src/pic_top.sv ====
// Prioritized interrupt controller top with APB registers and trap handling.
`timescale 1ns/1ps
module pic_top #(
    parameter int N_SRC = 56
) (
    // Clock and reset.
    input  wire logic                             clk_sys_i,
    input  wire logic                             rst_n_i,
    // APB slave.
    input  wire logic [pic_pkg::ADDR_W-1:0]       paddr_i,
    input  wire logic                             psel_i,
    input  wire logic                             penable_i,
    input  wire logic                             pwrite_i,
    input  wire logic [31:0]                      pwdata_i,
    input  wire logic [3:0]                       pstrb_i,
    output logic      [31:0]                      prdata_o,
    output logic                                  pready_o,
    output logic                                  pslverr_o,
    // Peripheral request and hardware trap events.
    input  wire logic [N_SRC-1:0]                 src_event_i,
    input  wire logic [pic_pkg::N_HWTRAP-1:0]     hw_trap_i,
    // Processor core handshake.
    input  wire logic [pic_pkg::LVL_W-1:0]        core_priority_level_i,
    input  wire logic                             core_ack_i,
    input  wire logic                             core_trap_ack_i,
    input  wire logic                             core_trap_done_i,
    output logic                                  int_req_o,
    output logic      [pic_pkg::TRAP_W-1:0]       int_trap_num_o,
    output logic      [pic_pkg::VEC_W-1:0]        int_vec_o,
    output logic      [pic_pkg::LVL_W-1:0]        int_lvl_o,
    output logic                                  trap_req_o,
    output logic      [pic_pkg::TRAP_W-1:0]       trap_num_o,
    output logic      [pic_pkg::VEC_W-1:0]        trap_vec_o,
    // Interrupt to the system.
    output logic                                  irq_o
);
    localparam int NT  = pic_pkg::N_HWTRAP;
    localparam int TLW = 3;

    initial begin
        if (N_SRC < 1 || N_SRC > pic_pkg::N_SRC_MAX) begin
            $error("N_SRC out of range.");
        end
    end

    pic_arb_if #(.N(N_SRC)) ab ();

    logic [pic_pkg::CW_W-1:0]   cw_r [N_SRC];
    logic [NT-1:0]              tfr_r;
    logic [NT-1:0]              tpend_r;
    logic [pic_pkg::IST_W-1:0]  ist_r;
    logic [pic_pkg::IST_W-1:0]  imsk_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic [31:0]                prdata_r;
    logic                       int_req_r;
    logic [pic_pkg::IDX_W-1:0]  int_idx_r;
    logic [pic_pkg::LVL_W-1:0]  int_lvl_r;
    logic                       int_blank_r;
    logic                       trap_req_r;
    logic [1:0]                 trap_idx_r;
    logic [TLW-1:0]             trap_level_r;
    logic                       trap_blank_r;
    logic                       irq_r;

    logic                       setup;
    logic                       access;
    logic                       wr_en;
    logic                       cw_hit;
    logic [pic_pkg::IDX_W-1:0]  cw_idx;
    logic                       addr_ok;
    logic [31:0]                rd_data;
    logic                       ack_fire;
    logic                       tack_fire;
    logic                       tpend_any;
    logic [1:0]                 ttop;

    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            ab.ctrl[i] = cw_r[i];
        end
    end

    pic_arbiter #(.N(N_SRC)) u_arb (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ab        (ab.arb)
    );

    // Bus decode: one wait-free access phase after every setup cycle.
    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i & pready_r;
    assign wr_en    = access & pwrite_i & ~pslverr_r & pstrb_i[0];
    assign cw_idx   = paddr_i[pic_pkg::IDX_W+1:2];
    assign cw_hit   = (paddr_i[1:0] == 2'b00) &&
                      (paddr_i < pic_pkg::ADDR_W'(N_SRC * 4));
    assign addr_ok  = cw_hit || paddr_i == pic_pkg::ADDR_TFR ||
                      paddr_i == pic_pkg::ADDR_IST || paddr_i == pic_pkg::ADDR_IMSK ||
                      paddr_i == pic_pkg::ADDR_STAT;
    assign ack_fire  = core_ack_i & int_req_r;
    assign tack_fire = core_trap_ack_i & trap_req_r;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (cw_hit) begin
            rd_data[pic_pkg::CW_W-1:0] = cw_r[cw_idx];
        end else if (paddr_i == pic_pkg::ADDR_TFR) begin
            rd_data[NT-1:0] = tfr_r;
        end else if (paddr_i == pic_pkg::ADDR_IST) begin
            rd_data[pic_pkg::IST_W-1:0] = ist_r;
        end else if (paddr_i == pic_pkg::ADDR_IMSK) begin
            rd_data[pic_pkg::IST_W-1:0] = imsk_r;
        end else if (paddr_i == pic_pkg::ADDR_STAT) begin
            rd_data[14:0] = {trap_level_r, ab.win_valid, int_req_r, ab.win_lvl, ab.win_idx};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~addr_ok;
            if (setup) begin
                prdata_r <= rd_data;
            end
        end
    end

    // Control words: write, hardware clear on acceptance, event set wins.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N_SRC; i++) begin
                cw_r[i] <= pic_pkg::CW_RST;
            end
        end else begin
            for (int i = 0; i < N_SRC; i++) begin
                logic [pic_pkg::CW_W-1:0] nxt;
                nxt = cw_r[i];
                if (wr_en && cw_hit && cw_idx == pic_pkg::IDX_W'(i)) begin
                    nxt = pwdata_i[pic_pkg::CW_W-1:0];
                end
                if (ack_fire && int_idx_r == pic_pkg::IDX_W'(i)) begin
                    nxt[pic_pkg::REQ_BIT] = 1'b0;
                end
                if (src_event_i[i]) begin
                    nxt[pic_pkg::REQ_BIT] = 1'b1;
                end
                cw_r[i] <= nxt;
            end
        end
    end

    // Standard request presented to the core.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_req_r   <= 1'b0;
            int_idx_r   <= '0;
            int_lvl_r   <= '0;
            int_blank_r <= 1'b0;
        end else begin
            int_blank_r <= ack_fire;
            int_req_r   <= ab.win_valid && !ack_fire && !int_blank_r &&
                           ab.win_lvl > core_priority_level_i &&
                           trap_level_r == '0 && !trap_req_r;
            if (!int_req_r || ack_fire) begin
                int_idx_r <= ab.win_idx;
                int_lvl_r <= ab.win_lvl;
            end else if (ab.win_valid) begin
                int_idx_r <= ab.win_idx;
                int_lvl_r <= ab.win_lvl;
            end
        end
    end

    // Hardware traps: flags, pending set and service level.
    always_comb begin
        tpend_any = |tpend_r;
        ttop      = '0;
        for (int t = 0; t < NT; t++) begin
            if (tpend_r[t]) begin
                ttop = 2'(t);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tfr_r <= '0;
        end else begin
            for (int t = 0; t < NT; t++) begin
                if (wr_en && paddr_i == pic_pkg::ADDR_TFR && pwdata_i[t]) begin
                    tfr_r[t] <= 1'b0;
                end
                if (hw_trap_i[t]) begin
                    tfr_r[t] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tpend_r      <= '0;
            trap_req_r   <= 1'b0;
            trap_idx_r   <= '0;
            trap_level_r <= '0;
            trap_blank_r <= 1'b0;
        end else begin
            for (int t = 0; t < NT; t++) begin
                if (tack_fire && trap_idx_r == 2'(t)) begin
                    tpend_r[t] <= 1'b0;
                end
                if (hw_trap_i[t]) begin
                    tpend_r[t] <= 1'b1;
                end
            end
            trap_blank_r <= tack_fire;
            trap_req_r   <= tpend_any && !tack_fire && !trap_blank_r &&
                            {1'b0, ttop} + 3'h1 >= trap_level_r;
            trap_idx_r   <= ttop;
            if (tack_fire) begin
                trap_level_r <= {1'b0, trap_idx_r} + 3'h1;
            end else if (core_trap_done_i) begin
                trap_level_r <= '0;
            end
        end
    end

    // Interrupt status, mask and system interrupt.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ist_r  <= '0;
            imsk_r <= '0;
            irq_r  <= 1'b0;
        end else begin
            if (wr_en && paddr_i == pic_pkg::ADDR_IMSK) begin
                imsk_r <= pwdata_i[pic_pkg::IST_W-1:0];
            end
            for (int b = 0; b < pic_pkg::IST_W; b++) begin
                if (wr_en && paddr_i == pic_pkg::ADDR_IST && pwdata_i[b]) begin
                    ist_r[b] <= 1'b0;
                end
            end
            if (|hw_trap_i) begin
                ist_r[pic_pkg::IST_TRAP] <= 1'b1;
            end
            if (ack_fire) begin
                ist_r[pic_pkg::IST_ACK] <= 1'b1;
            end
            irq_r <= |(ist_r & imsk_r);
        end
    end

    assign prdata_o       = prdata_r;
    assign pready_o       = pready_r;
    assign pslverr_o      = pslverr_r;
    assign int_req_o      = int_req_r;
    assign int_trap_num_o = pic_pkg::src_trap_num(int'(int_idx_r));
    assign int_vec_o      = {pic_pkg::src_trap_num(int'(int_idx_r)), 2'b00};
    assign int_lvl_o      = int_lvl_r;
    assign trap_req_o     = trap_req_r;
    assign trap_num_o     = pic_pkg::TN_HW[trap_idx_r*pic_pkg::TRAP_W +: pic_pkg::TRAP_W];
    assign trap_vec_o     = {trap_num_o, 2'b00};
    assign irq_o          = irq_r;

    a_vec_times_four: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        int_req_o |-> int_vec_o[pic_pkg::VEC_W-1:2] == int_trap_num_o && int_vec_o[1:0] == 2'b00)
        else $error("Vector is not four times the trap number.");

    a_cc_low_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        int_req_o && int_idx_r < pic_pkg::IDX_W'(pic_pkg::IDX_CC_MID) |->
        int_trap_num_o == pic_pkg::TN_CC_LO + pic_pkg::TRAP_W'(int_idx_r))
        else $error("Capture channel trap number wrong.");

    a_timer_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        int_req_o && int_idx_r == pic_pkg::IDX_W'(pic_pkg::IDX_CT7) |->
        int_trap_num_o == pic_pkg::TN_CT7)
        else $error("Capture timer trap number wrong.");

    a_trap_reacts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hw_trap_i[NT-1] |-> ##[1:3] ((trap_req_o && trap_idx_r == 2'(NT-1)) || trap_level_r == 3'(NT)))
        else $error("Hardware trap not presented.");

    a_trap_flagged: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hw_trap_i[0] |=> tfr_r[0])
        else $error("Trap flag not set.");

    a_trap_preempt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trap_req_o |-> {1'b0, trap_idx_r} + 3'h1 >= trap_level_r)
        else $error("Trap presented below the service in progress.");

    a_trap_no_int: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trap_level_r != '0 |=> !int_req_o)
        else $error("Standard request during trap service.");

    a_above_cpu: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(int_req_o) |-> int_lvl_o > $past(core_priority_level_i))
        else $error("Request not above processor priority.");

    a_ack_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ack_fire && !src_event_i[int_idx_r] && !wr_en |=> !cw_r[$past(int_idx_r)][pic_pkg::REQ_BIT])
        else $error("Accepted request flag not cleared.");

    a_high_byte_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        setup && cw_hit |=> prdata_o[31:pic_pkg::CW_W] == '0)
        else $error("Reserved control word bits read non-zero.");
endmodule

// ==== tb/pic_core_model.sv ====
// Behavioural processor core that accepts standard requests and hardware traps.
`timescale 1ns/1ps
module pic_core_model (
    // Clock and reset.
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    // Controller requests.
    input  wire logic                        int_req_i,
    input  wire logic [pic_pkg::TRAP_W-1:0]  int_trap_num_i,
    input  wire logic                        trap_req_i,
    input  wire logic [pic_pkg::TRAP_W-1:0]  trap_num_i,
    // Test controls.
    input  wire logic                        auto_i,
    input  wire logic [3:0]                  delay_i,
    // Core answers.
    output logic                             core_ack_o,
    output logic                             core_trap_ack_o,
    output logic                             core_trap_done_o,
    output logic      [pic_pkg::TRAP_W-1:0]  last_int_num_o
);
    logic [3:0] wait_r;
    logic [4:0] svc_r;

    // Accepts a presented request after a programmable wait.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_ack_o     <= 1'b0;
            wait_r         <= 4'h0;
            last_int_num_o <= 7'h00;
        end else begin
            core_ack_o <= 1'b0;
            if (core_ack_o && int_req_i) begin
                last_int_num_o <= int_trap_num_i;
            end
            if (int_req_i && !core_ack_o && auto_i) begin
                if (wait_r >= delay_i) begin
                    core_ack_o <= 1'b1;
                    wait_r     <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end

    // Accepts a trap at once and ends its service some cycles later.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_trap_ack_o  <= 1'b0;
            core_trap_done_o <= 1'b0;
            svc_r            <= 5'h00;
        end else begin
            core_trap_ack_o  <= 1'b0;
            core_trap_done_o <= 1'b0;
            if (trap_req_i && !core_trap_ack_o && auto_i) begin
                core_trap_ack_o <= 1'b1;
                svc_r           <= 5'h1f;
            end else if (svc_r == 5'h01) begin
                core_trap_done_o <= 1'b1;
                svc_r            <= 5'h00;
            end else if (svc_r != 5'h00) begin
                svc_r <= svc_r - 5'h01;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking testbench of the interrupt controller.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h", $time, g); end end
module tb;
    typedef struct {int idx; logic [6:0] tn;} pic_row_type;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [31:0] pwdata_i  = 32'h0;
    logic [3:0]  pstrb_i   = 4'hf;
    logic [55:0] src_i     = '0;
    logic [3:0]  hw_i      = 4'h0;
    logic [3:0]  priority_level      = 4'h0;
    logic        auto      = 1'b1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, perr, er, ireq, treq, irq, ack, tack, tdone;
    logic [6:0]  inum, tnum, lin;
    logic [8:0]  ivec, tvec;
    logic [3:0]  ilv;
    int          n_fail = 0;
    int          checks = 0;
    pic_row_type rows [18] = '{'{0, 7'h10}, '{15, 7'h1f}, '{16, 7'h30}, '{28, 7'h3c}, '{29, 7'h44}, '{31, 7'h46},
        '{32, 7'h20}, '{33, 7'h21}, '{34, 7'h3d}, '{35, 7'h3e}, '{36, 7'h22}, '{43, 7'h29}, '{44, 7'h2a},
        '{45, 7'h47}, '{46, 7'h2b}, '{51, 7'h3f}, '{52, 7'h40}, '{55, 7'h43}};

    pic_top dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .src_event_i(src_i), .hw_trap_i(hw_i), .core_priority_level_i(priority_level), .core_ack_i(ack),
        .core_trap_ack_i(tack), .core_trap_done_i(tdone), .int_req_o(ireq), .int_trap_num_o(inum),
        .int_vec_o(ivec), .int_lvl_o(ilv), .trap_req_o(treq), .trap_num_o(tnum), .trap_vec_o(tvec), .irq_o(irq)
    );
    pic_core_model core (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .int_req_i(ireq), .int_trap_num_i(inum), .trap_req_i(treq),
        .trap_num_i(tnum), .auto_i(auto), .delay_i(4'h2), .core_ack_o(ack), .core_trap_ack_o(tack),
        .core_trap_done_o(tdone), .last_int_num_o(lin)
    );

    always #2 clk_sys_i = ~clk_sys_i;

    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        paddr_i   <= a;
        pwrite_i  <= w;
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = perr;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            $display("unexpected at %0t: no ready", $time);
            conclude();
        end
    endtask

    task automatic wt(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (((s == 0) ? ireq : treq) !== 1'b1 && n < 60);
        if (n >= 60) begin
            n_fail++;
            $display("unexpected at %0t: no request", $time);
            conclude();
        end
    endtask

    task automatic ev(input logic [55:0] s, input logic [3:0] h);
        @(posedge clk_sys_i);
        src_i <= s;
        hw_i  <= h;
        @(posedge clk_sys_i);
        src_i <= '0;
        hw_i  <= 4'h0;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK({ireq, treq, irq}, 3'b000)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0)
        foreach (rows[k]) begin
            apb(1'b1, 12'(rows[k].idx * 4), 32'h54);
            ev(56'(1) << rows[k].idx, 4'h0);
            wt(0);
            `CHK(inum, rows[k].tn)
            `CHK(ivec, {rows[k].tn, 2'b00})
            repeat (6) @(posedge clk_sys_i);
            `CHK(lin, rows[k].tn)
            apb(1'b0, 12'(rows[k].idx * 4), 32'h0);
            `CHK(rd, 32'h54)
            apb(1'b1, 12'(rows[k].idx * 4), 32'h0);
        end
        auto <= 1'b0;
        apb(1'b1, 12'h00c, 32'h4c);
        apb(1'b1, 12'h01c, 32'h4e);
        apb(1'b1, 12'h024, 32'h4b);
        apb(1'b1, 12'h030, 32'h3c);
        ev(56'h1288, 4'h0);
        wt(0);
        repeat (3) @(posedge clk_sys_i);
        `CHK({inum, ilv}, {7'h17, 4'h3})
        apb(1'b0, 12'h030, 32'h0);
        `CHK(rd, 32'hbc)
        apb(1'b0, 12'h10c, 32'h0);
        `CHK(rd, 32'h0000_0cc7)
        priority_level <= 4'h3;
        repeat (4) @(posedge clk_sys_i);
        `CHK(ireq, 1'b0)
        priority_level <= 4'h2;
        auto <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        `CHK({ireq, lin}, {1'b0, 7'h13})
        priority_level <= 4'h0;
        wt(0);
        `CHK(inum, 7'h19)
        priority_level <= 4'hf;
        apb(1'b1, 12'h014, 32'hffff_ffd7);
        apb(1'b0, 12'h014, 32'h0);
        `CHK(rd, 32'hd7)
        pstrb_i <= 4'h0;
        apb(1'b1, 12'h014, 32'h0);
        pstrb_i <= 4'hf;
        apb(1'b0, 12'h014, 32'h0);
        `CHK(rd, 32'hd7)
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b0, 12'h0e2, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        priority_level <= 4'h0;
        apb(1'b1, 12'h108, 32'h3);
        apb(1'b1, 12'h050, 32'h7c);
        ev(56'h0, 4'h1);
        wt(1);
        `CHK({tnum, tvec}, {7'h0a, 9'h028})
        ev(56'(1) << 20, 4'h0);
        repeat (8) @(posedge clk_sys_i);
        `CHK({ireq, irq}, 2'b01)
        apb(1'b0, 12'h100, 32'h0);
        `CHK(rd, 32'h1)
        ev(56'h0, 4'h8);
        wt(1);
        `CHK({tnum, tvec}, {7'h02, 9'h008})
        wt(0);
        `CHK(inum, 7'h34)
        repeat (8) @(posedge clk_sys_i);
        apb(1'b0, 12'h100, 32'h0);
        `CHK(rd, 32'h9)
        apb(1'b1, 12'h100, 32'hf);
        apb(1'b1, 12'h104, 32'h3);
        apb(1'b0, 12'h100, 32'h0);
        `CHK({irq, rd}, {1'b0, 32'h0})
        conclude();
    end
endmodule
